// *** lp_sequencer.sv ***
// Standby and halt entry and wake sequencer with clock, oscillator and PLL gating.
// Assumes the idle strobe and control writes come from core logic on the same clock,
// and that wake pins are asynchronous and active low.
// Notes on behaviour
// - Idle in standby mode stops system clock.
// - Idle in halt mode enters halt.
// - Standby entry keeps clock 32 cycles first.
// - Halt entry keeps clock 32 cycles first.
// - Halt turns off clocks, oscillator and PLL.
// - Active nonmaskable pin restarts oscillator only.
// - Pin release starts PLL lock count.
// - Core clock back, leave halt, serve interrupt.
// - Standby wake resumes after latency, serves interrupt.
// - Wake pulse qualified by 6-bit count.
// - Standby resume after 12 or 1125 cycles.
// - Halt resume 1125 or 35 after lock.
// - Last clock edge 32 cycles after idle.
// - Resume at instruction after the idle.
`timescale 1ns/1ps
module lp_sequencer #(
   parameter int unsigned PLL_LOCK_CYCLES = lp_seq_pkg::PLL_LOCK_CYCLES
) (
   // Clock and reset
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_RESET_N,
   // Core side
   input  wire logic       I_IDLE_EXEC,
   input  wire logic       I_CTRL_WRITE,
   input  wire logic [1:0] I_CTRL_MODE,
   input  wire logic [5:0] I_CTRL_QUALIFY,
   input  wire logic       I_CTRL_QUAL_EN,
   input  wire logic       I_FLASH_ASLEEP,
   input  wire logic       I_WAKE_IRQ_ENABLED,
   // Wake pins
   input  wire logic       I_WAKE_INT_N,
   input  wire logic       I_NONMASKABLE_WAKE_PIN_N,
   input  wire logic       I_RESET_PIN_N,
   // Clock gating
   output logic            O_SYSTEM_CLOCK_EN,
   output logic            O_CORE_CLOCK_EN,
   output logic            O_OSCILLATOR_EN,
   output logic            O_PLL_EN,
   // Status
   output logic            O_IN_STANDBY,
   output logic            O_IN_HALT,
   output logic            O_RESUME,
   output logic            O_SERVICE_INTERRUPT
);
   lp_seq_pkg::state_t                    state;
   logic [lp_seq_pkg::CNT_W-1:0]          count;
   logic [1:0]                            lp_mode;
   logic [5:0]                            standby_wake_qualify_count;
   logic                                  qual_en;
   logic [lp_seq_pkg::PIN_COUNT-1:0]      sync1;
   logic [lp_seq_pkg::PIN_COUNT-1:0]      sync2;
   wire  [lp_seq_pkg::PIN_COUNT-1:0]      pin_active = ~sync2;
   logic [lp_seq_pkg::QCNT_W-1:0]         wake_threshold;
   logic                                  wake_hit;
   logic                                  nmi_hit;
   logic                                  rst_hit;
   logic                                  idle_taken;
   logic [lp_seq_pkg::CNT_W-1:0]          lock_seen;

   // Latency from the wake decision to the first instruction after the idle.
   function automatic logic [lp_seq_pkg::CNT_W-1:0] resume_latency(input logic asleep, input logic halt);
      if (asleep) begin
         resume_latency = lp_seq_pkg::CNT_W'(lp_seq_pkg::FLASH_SLEEP_CYCLES - 1);
      end else if (halt) begin
         resume_latency = lp_seq_pkg::CNT_W'(lp_seq_pkg::HALT_SARAM_CYCLES - 1);
      end else begin
         resume_latency = lp_seq_pkg::CNT_W'(lp_seq_pkg::STBY_FAST_CYCLES - 1);
      end
   endfunction : resume_latency

   // Two-flop synchronisers hold the raw pin level and reset to the released level, so no false wake follows reset.
   generate
      for (genvar g = 0; g < lp_seq_pkg::PIN_COUNT; g++) begin : g_sync
         logic pin_n;
         if (g == lp_seq_pkg::PIN_WAKE) begin : g_w
            assign pin_n = I_WAKE_INT_N;
         end else if (g == lp_seq_pkg::PIN_NMI) begin : g_n
            assign pin_n = I_NONMASKABLE_WAKE_PIN_N;
         end else begin : g_r
            assign pin_n = I_RESET_PIN_N;
         end
         always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
               sync1[g] <= 1'b1;
               sync2[g] <= 1'b1;
            end else begin
               sync1[g] <= pin_n;
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         lp_mode                    <= lp_seq_pkg::MODE_RESET;
         standby_wake_qualify_count <= lp_seq_pkg::QUAL_RESET;
         qual_en                    <= 1'b0;
      end else if (I_CTRL_WRITE) begin
         lp_mode                    <= I_CTRL_MODE;
         standby_wake_qualify_count <= I_CTRL_QUALIFY;
         qual_en                    <= I_CTRL_QUAL_EN;
      end
   end

   assign wake_threshold = qual_en
      ? lp_seq_pkg::QCNT_W'(lp_seq_pkg::WAKE_QUAL_BASE + standby_wake_qualify_count)
      : lp_seq_pkg::QCNT_W'(lp_seq_pkg::WAKE_UNQUAL_CYCLES);

   pulse_qualifier u_wake_qual (
      .i_clk       (I_SYS_CLK),
      .i_reset_n   (I_RESET_N),
      .i_active    (pin_active[lp_seq_pkg::PIN_WAKE]),
      .i_threshold (wake_threshold),
      .o_hit       (wake_hit)
   );

   // Nonmaskable wake needs two active cycles
   pulse_qualifier u_nmi_qual (
      .i_clk       (I_SYS_CLK),
      .i_reset_n   (I_RESET_N),
      .i_active    (pin_active[lp_seq_pkg::PIN_NMI]),
      .i_threshold (lp_seq_pkg::QCNT_W'(lp_seq_pkg::NMI_WAKE_CYCLES)),
      .o_hit       (nmi_hit)
   );

   // Reset wake needs eight active cycles
   pulse_qualifier u_rst_qual (
      .i_clk       (I_SYS_CLK),
      .i_reset_n   (I_RESET_N),
      .i_active    (pin_active[lp_seq_pkg::PIN_RST]),
      .i_threshold (lp_seq_pkg::QCNT_W'(lp_seq_pkg::RST_WAKE_CYCLES)),
      .o_hit       (rst_hit)
   );

   assign idle_taken = (state == lp_seq_pkg::ST_RUN) && I_IDLE_EXEC;

   // Plain idle leaves the clocks alone; it is handled by the core itself.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state <= lp_seq_pkg::ST_RUN;
         count <= '0;
      end else begin
         unique case (state)
            lp_seq_pkg::ST_RUN: begin
               if (idle_taken && lp_mode == lp_seq_pkg::MODE_STANDBY) begin
                  state <= lp_seq_pkg::ST_FLUSH_STBY;
                  count <= lp_seq_pkg::CNT_W'(lp_seq_pkg::FLUSH_CYCLES - 1);
               end else if (idle_taken && lp_mode == lp_seq_pkg::MODE_HALT) begin
                  state <= lp_seq_pkg::ST_FLUSH_HALT;
                  count <= lp_seq_pkg::CNT_W'(lp_seq_pkg::FLUSH_CYCLES - 1);
               end
            end
            lp_seq_pkg::ST_FLUSH_STBY: begin
               if (count == '0) begin
                  state <= lp_seq_pkg::ST_STANDBY;
               end else begin
                  count <= count - 1'b1;
               end
            end
            // Qualified wake starts the resume latency
            lp_seq_pkg::ST_STANDBY: begin
               if (wake_hit || nmi_hit || rst_hit) begin
                  state <= lp_seq_pkg::ST_STBY_RESUME;
                  count <= resume_latency(I_FLASH_ASLEEP, 1'b0);
               end
            end
            lp_seq_pkg::ST_FLUSH_HALT: begin
               if (count == '0) begin
                  state <= lp_seq_pkg::ST_HALT;
               end else begin
                  count <= count - 1'b1;
               end
            end
            // Oscillator restarts on a qualified nonmaskable wake or reset pin, not on the wake interrupt pin
            lp_seq_pkg::ST_HALT: begin
               if (nmi_hit || rst_hit) begin
                  state <= lp_seq_pkg::ST_HALT_OSC;
               end
            end
            lp_seq_pkg::ST_HALT_OSC: begin
               if (!pin_active[lp_seq_pkg::PIN_NMI] && !pin_active[lp_seq_pkg::PIN_RST]) begin
                  state <= lp_seq_pkg::ST_PLL_LOCK;
                  count <= lp_seq_pkg::CNT_W'(PLL_LOCK_CYCLES - 1);
               end
            end
            lp_seq_pkg::ST_PLL_LOCK: begin
               if (count == '0) begin
                  state <= lp_seq_pkg::ST_HALT_RESUME;
                  count <= resume_latency(I_FLASH_ASLEEP, 1'b1);
               end else begin
                  count <= count - 1'b1;
               end
            end
            lp_seq_pkg::ST_HALT_RESUME, lp_seq_pkg::ST_STBY_RESUME: begin
               if (count == '0) begin
                  state <= lp_seq_pkg::ST_RUN;
               end else begin
                  count <= count - 1'b1;
               end
            end
         endcase
      end
   end

   // Clock, oscillator and PLL enables follow the state
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_SYSTEM_CLOCK_EN <= 1'b1;
         O_CORE_CLOCK_EN   <= 1'b1;
         O_OSCILLATOR_EN   <= 1'b1;
         O_PLL_EN          <= 1'b1;
         O_IN_STANDBY      <= 1'b0;
         O_IN_HALT         <= 1'b0;
      end else begin
         O_SYSTEM_CLOCK_EN <= !(state == lp_seq_pkg::ST_STANDBY || state == lp_seq_pkg::ST_HALT ||
                                state == lp_seq_pkg::ST_HALT_OSC || state == lp_seq_pkg::ST_PLL_LOCK) ||
                              ((state == lp_seq_pkg::ST_STANDBY) && (wake_hit || nmi_hit || rst_hit)) ||
                              ((state == lp_seq_pkg::ST_PLL_LOCK) && count == '0);
         if ((state == lp_seq_pkg::ST_FLUSH_STBY || state == lp_seq_pkg::ST_FLUSH_HALT) && count == '0) begin
            O_SYSTEM_CLOCK_EN <= 1'b0;
         end
         O_CORE_CLOCK_EN   <= !(state == lp_seq_pkg::ST_HALT || state == lp_seq_pkg::ST_HALT_OSC ||
                                state == lp_seq_pkg::ST_PLL_LOCK || state == lp_seq_pkg::ST_FLUSH_HALT
                                && count == '0) || (state == lp_seq_pkg::ST_PLL_LOCK && count == '0);
         O_OSCILLATOR_EN   <= !(state == lp_seq_pkg::ST_HALT && !(nmi_hit || rst_hit)) &&
                              !(state == lp_seq_pkg::ST_FLUSH_HALT && count == '0);
         O_PLL_EN          <= !(state == lp_seq_pkg::ST_HALT || state == lp_seq_pkg::ST_HALT_OSC &&
                                (pin_active[lp_seq_pkg::PIN_NMI] || pin_active[lp_seq_pkg::PIN_RST])) &&
                              !(state == lp_seq_pkg::ST_FLUSH_HALT && count == '0);
         O_IN_STANDBY      <= (state == lp_seq_pkg::ST_FLUSH_STBY && count == '0) ||
                              (state == lp_seq_pkg::ST_STANDBY && !(wake_hit || nmi_hit || rst_hit));
         O_IN_HALT         <= (state == lp_seq_pkg::ST_FLUSH_HALT && count == '0) ||
                              state == lp_seq_pkg::ST_HALT || state == lp_seq_pkg::ST_HALT_OSC ||
                              (state == lp_seq_pkg::ST_PLL_LOCK && count != '0);
      end
   end

   // Resume pulse, with interrupt service only when enabled
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RESUME            <= 1'b0;
         O_SERVICE_INTERRUPT <= 1'b0;
      end else begin
         O_RESUME            <= (state == lp_seq_pkg::ST_HALT_RESUME || state == lp_seq_pkg::ST_STBY_RESUME)
                                && count == '0;
         O_SERVICE_INTERRUPT <= (state == lp_seq_pkg::ST_HALT_RESUME || state == lp_seq_pkg::ST_STBY_RESUME)
                                && count == '0 && I_WAKE_IRQ_ENABLED;
      end
   end

   // Cycles spent waiting for lock, read only by the checks below.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         lock_seen <= '0;
      end else if (state == lp_seq_pkg::ST_PLL_LOCK) begin
         lock_seen <= lock_seen + 1'b1;
      end else if (state == lp_seq_pkg::ST_RUN) begin
         lock_seen <= '0;
      end
   end

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESET_N);

   sequence s_flush;
      ##32 O_SYSTEM_CLOCK_EN ##1 !O_SYSTEM_CLOCK_EN;
   endsequence

   a_standby_entry: assert property (idle_taken && lp_mode == lp_seq_pkg::MODE_STANDBY |-> s_flush ##0 O_IN_STANDBY)
      else $error("standby entry did not stop the clock after the drain");
   a_halt_entry: assert property (idle_taken && lp_mode == lp_seq_pkg::MODE_HALT |-> s_flush ##0 (O_IN_HALT && !O_OSCILLATOR_EN))
      else $error("halt entry did not stop the oscillator after the drain");
   a_halt_all_off: assert property (O_IN_HALT && !$past(O_IN_HALT) |-> !O_SYSTEM_CLOCK_EN && !O_CORE_CLOCK_EN && !O_OSCILLATOR_EN && !O_PLL_EN)
      else $error("clock or oscillator still on in halt");
   a_nmi_osc_only: assert property ($rose(O_OSCILLATOR_EN) && O_IN_HALT |-> !O_PLL_EN && !O_CORE_CLOCK_EN)
      else $error("PLL or core clock on with the oscillator restart");
   a_pll_lock_wait: assert property ($rose(O_CORE_CLOCK_EN) |-> lock_seen == lp_seq_pkg::CNT_W'(PLL_LOCK_CYCLES))
      else $error("core clock enabled before the lock wait ended");
   a_halt_saram_resume: assert property ($rose(O_CORE_CLOCK_EN) && !I_FLASH_ASLEEP |-> ##35 O_RESUME)
      else $error("halt resume latency wrong");
   a_standby_resume: assert property (state == lp_seq_pkg::ST_STANDBY && wake_hit && !I_FLASH_ASLEEP |=> O_SYSTEM_CLOCK_EN ##12 O_RESUME)
      else $error("standby resume latency wrong");
   a_wake_unqual_width: assert property ($rose(wake_hit) && !qual_en |-> $past(pin_active[lp_seq_pkg::PIN_WAKE], 11))
      else $error("wake accepted before twelve active cycles");
   a_irq_with_resume: assert property (O_SERVICE_INTERRUPT |-> O_RESUME && $past(I_WAKE_IRQ_ENABLED))
      else $error("interrupt served without resume or enable");
   a_plain_idle: assert property (idle_taken && lp_mode == lp_seq_pkg::MODE_IDLE |=> state == lp_seq_pkg::ST_RUN && O_SYSTEM_CLOCK_EN)
      else $error("plain idle changed the clocks");
endmodule : lp_sequencer

// *** lp_seq_pkg.sv ***
// Constants, encodings and state type for the low-power standby and halt sequencer.
// Assumes the core clock domain and the oscillator input run at the same 100 MHz rate.
package lp_seq_pkg;
   localparam int unsigned CLK_MHZ            = 100;
   localparam int unsigned CNT_W              = 18;
   localparam int unsigned QUAL_W             = 6;
   localparam int unsigned QCNT_W             = 7;
   // Cycle figures of the entry and wake sequences.
   localparam int unsigned FLUSH_CYCLES       = 32;
   localparam int unsigned HALT_EDGE_TYP      = 45;
   localparam int unsigned PLL_LOCK_CYCLES    = 131072;
   localparam int unsigned STBY_FAST_CYCLES   = 12;
   localparam int unsigned FLASH_SLEEP_CYCLES = 1125;
   localparam int unsigned HALT_SARAM_CYCLES  = 35;
   localparam int unsigned WAKE_UNQUAL_CYCLES = 12;
   localparam int unsigned WAKE_QUAL_BASE     = 2;
   localparam int unsigned NMI_WAKE_CYCLES    = 2;
   localparam int unsigned RST_WAKE_CYCLES    = 8;
   // Low-power mode selection field.
   localparam logic [1:0]  MODE_IDLE          = 2'h0;
   localparam logic [1:0]  MODE_STANDBY       = 2'h1;
   localparam logic [1:0]  MODE_HALT          = 2'h2;
   localparam logic [1:0]  MODE_RESET         = 2'h0;
   localparam logic [5:0]  QUAL_RESET         = 6'h00;
   // Pin index of the synchroniser bank.
   localparam int unsigned PIN_WAKE           = 0;
   localparam int unsigned PIN_NMI            = 1;
   localparam int unsigned PIN_RST            = 2;
   localparam int unsigned PIN_COUNT          = 3;

   typedef enum logic [3:0] {
      ST_RUN, ST_FLUSH_STBY, ST_STANDBY, ST_STBY_RESUME,
      ST_FLUSH_HALT, ST_HALT, ST_HALT_OSC, ST_PLL_LOCK, ST_HALT_RESUME
   } state_t;
endpackage : lp_seq_pkg

// *** pulse_qualifier.sv ***
// Counts consecutive active cycles of a synchronised wake level.
// Assumes its input is already synchronised to the clock.
`timescale 1ns/1ps
module pulse_qualifier (
   // Clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_reset_n,
   // Level and threshold
   input  wire logic                           i_active,
   input  wire logic [lp_seq_pkg::QCNT_W-1:0] i_threshold,
   // Result
   output logic                                o_hit
);
   logic [lp_seq_pkg::QCNT_W-1:0] count;

   // The count saturates so a long pulse never wraps back below the threshold.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count <= '0;
      end else if (!i_active) begin
         count <= '0;
      end else if (count != {lp_seq_pkg::QCNT_W{1'b1}}) begin
         count <= count + 1'b1;
      end
   end

   // The present active sample counts too, so a pulse of exactly the threshold length is taken.
   assign o_hit = i_active && (count >= i_threshold - 1'b1);
endmodule : pulse_qualifier

// *** wake_source.sv ***
// Behavioural model of the external wake sources: wake interrupt, nonmaskable wake pin and reset pin.
// Assumes active-low pins with pull-ups and a bench that commands each pulse on a falling clock edge.
`timescale 1ns/1ps
module wake_source (
   // Clock
   input  wire logic       i_clk,
   // Command from the bench
   input  wire logic       i_go,
   input  wire logic [1:0] i_pin,
   input  wire logic [7:0] i_width,
   // Wake pins
   output logic            o_wake_int_n,
   output logic            o_nonmaskable_wake_pin_n,
   output logic            o_reset_pin_n
);
   int         left = 0;
   logic [1:0] pin  = 2'h0;

   always @(negedge i_clk) begin
      if (i_go && left == 0) begin
         left <= int'(i_width);
         pin  <= i_pin;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end

   // Released pins return to their pull-up level, never to a stale value.
   assign o_wake_int_n             = !(left > 0 && pin == 2'h0);
   assign o_nonmaskable_wake_pin_n = !(left > 0 && pin == 2'h1);
   assign o_reset_pin_n            = !(left > 0 && pin == 2'h2);
endmodule : wake_source

// *** test_lp_sequencer.sv ***
// Self-checking testbench of the standby and halt sequencer, with the wake source model on its pins.
// Assumes a shortened lock count of 16 cycles and one 100 MHz clock for system and oscillator.
`timescale 1ns/1ps
module test_lp_sequencer;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       idle = 1'b0, wr = 1'b0, qen = 1'b0, flash = 1'b0, irq_en = 1'b0, go = 1'b0;
   logic [1:0] mode = 2'h0, pin = 2'h0;
   logic [5:0] qual = 6'h00;
   logic [7:0] width = 8'h00;
   logic       wake_n, nmi_n, rst_n;
   logic       sys_en, core_en, osc_en, pll_en, in_stby, in_halt, resume, svc;
   int         err_count = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         n;

   always #5 sys_clk = ~sys_clk;

   wake_source src (.i_clk(sys_clk), .i_go(go), .i_pin(pin), .i_width(width), .o_wake_int_n(wake_n),
                    .o_nonmaskable_wake_pin_n(nmi_n), .o_reset_pin_n(rst_n));

   lp_sequencer #(.PLL_LOCK_CYCLES(16)) uut (
      .I_SYS_CLK(sys_clk), .I_RESET_N(reset_n), .I_IDLE_EXEC(idle), .I_CTRL_WRITE(wr),
      .I_CTRL_MODE(mode), .I_CTRL_QUALIFY(qual), .I_CTRL_QUAL_EN(qen), .I_FLASH_ASLEEP(flash),
      .I_WAKE_IRQ_ENABLED(irq_en), .I_WAKE_INT_N(wake_n), .I_NONMASKABLE_WAKE_PIN_N(nmi_n),
      .I_RESET_PIN_N(rst_n), .O_SYSTEM_CLOCK_EN(sys_en), .O_CORE_CLOCK_EN(core_en),
      .O_OSCILLATOR_EN(osc_en), .O_PLL_EN(pll_en), .O_IN_STANDBY(in_stby), .O_IN_HALT(in_halt),
      .O_RESUME(resume), .O_SERVICE_INTERRUPT(svc));

   task automatic tally_and_finish();
      $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic ctrl(input logic [1:0] m, input logic [5:0] q, input logic qe);
      wr <= 1'b1;
      mode <= m;
      qual <= q;
      qen <= qe;
      @(negedge sys_clk);
      wr <= 1'b0;
   endtask : ctrl

   // Idle taken at edge 0; the clock must still run at edge 32 and be gated at edge 33.
   task automatic enter();
      idle <= 1'b1;
      @(negedge sys_clk);
      idle <= 1'b0;
      repeat (31) @(negedge sys_clk);
      check(sys_en, 1, "clock gated early");
      @(negedge sys_clk);
      check(sys_en, 0, "clock not gated");
   endtask : enter

   task automatic wake(input logic [1:0] p, input logic [7:0] w);
      go <= 1'b1;
      pin <= p;
      width <= w;
      @(negedge sys_clk);
      go <= 1'b0;
   endtask : wake

   task automatic count_until(input int which, input int limit, output int cnt);
      logic hit;
      hit = 1'b0;
      cnt = 0;
      while (!hit && cnt < limit) begin
         @(negedge sys_clk);
         cnt++;
         case (which)
            0: hit = (resume === 1'b1);
            1: hit = (pll_en === 1'b1);
            2: hit = (core_en === 1'b1);
            default: hit = (osc_en === 1'b1);
         endcase
      end
      check(hit, 1, "wait ran out");
   endtask : count_until

   task automatic test_plain_idle();
      check({core_en, osc_en, pll_en, sys_en, in_stby, in_halt}, 6'h3c, "reset state");
      enter_plain();
      $display("test plain idle done");
   endtask : test_plain_idle

   task automatic enter_plain();
      idle <= 1'b1;
      @(negedge sys_clk);
      idle <= 1'b0;
      repeat (40) @(negedge sys_clk);
      check({sys_en, in_stby, in_halt}, 3'h4, "plain idle changed state");
   endtask : enter_plain

   task automatic test_standby_unqualified();
      ctrl(lp_seq_pkg::MODE_STANDBY, 6'h00, 1'b0);
      irq_en <= 1'b1;
      enter();
      check(in_stby, 1, "not in standby");
      wake(2'h0, 8'd11);
      repeat (40) @(negedge sys_clk);
      check(in_stby, 1, "short pulse woke");
      wake(2'h0, 8'd12);
      count_until(0, 60, n);
      check(n >= 24 && n <= 30, 1, "standby resume delay");
      check({svc, sys_en, in_stby}, 3'h6, "standby exit state");
      $display("test standby unqualified done");
   endtask : test_standby_unqualified

   task automatic test_standby_qualified();
      ctrl(lp_seq_pkg::MODE_STANDBY, 6'h03, 1'b1);
      irq_en <= 1'b0;
      flash <= 1'b1;
      enter();
      wake(2'h0, 8'd5);
      count_until(0, 1200, n);
      check(n >= 1130 && n <= 1136, 1, "flash asleep resume delay");
      check(svc, 0, "interrupt served while disabled");
      $display("test standby qualified done");
   endtask : test_standby_qualified

   task automatic test_halt(input logic [1:0] p, input logic [7:0] w, input logic fl, input int lo);
      ctrl(lp_seq_pkg::MODE_HALT, 6'h00, 1'b0);
      irq_en <= 1'b1;
      flash <= fl;
      enter();
      check({core_en, osc_en, pll_en, in_halt}, 4'h1, "halt state");
      wake(p, w);
      // The reset pin needs eight synchronised cycles, so wait for the oscillator instead of a fixed delay.
      count_until(3, 30, n);
      check({osc_en, pll_en}, 2'h2, "oscillator restart");
      count_until(1, 30, n);
      count_until(2, 40, n);
      check(n, 16, "lock time");
      check({sys_en, in_halt}, 2'h2, "halt exit");
      count_until(0, 1200, n);
      check(n >= lo && n <= lo + 2, 1, "halt resume delay");
      check(svc, 1, "interrupt not served");
      $display("test halt done");
   endtask : test_halt

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (20) @(negedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      test_plain_idle();
      test_standby_unqualified();
      test_standby_qualified();
      test_halt(2'h1, 8'd8, 1'b0, 35);
      test_halt(2'h2, 8'd8, 1'b1, 1125);
      tally_and_finish();
   end
endmodule : test_lp_sequencer
